// >>> hw/scp_clock_ctrl.sv
/*
 * scp_clock_ctrl: system clock prescaler, clock output pin drive and
 * pll control/status registers.
 * assumes: byte register port, read data one cycle after the read strobe;
 * fuse inputs are static; the pll and oscillators are outside.
 */
// Notes on behaviour
// - fuse drives system clock onto output pin
// - pin carries the divided clock
// - divided clock gates cpu, flash, io, adc
// - divisor changes only at period boundary
// - new rate after two edges
// - change enable written only with others zero
// - enable self-clears after four cycles, no restart
// - reset divisor zero, or three with fuse
// - divisor codes up to eight writable regardless of fuse
// - code n divides by two to the n
// - halver set before enabling pll
// - enable starts pll and oscillator if selected
// - lock flag read-only, clears with enable
// - reserved control bits read zero
// - pll output feeds usb and timer postscalers
// - source select: halver or rc oscillator
// - usb postdivider: pass or halve
`timescale 1ns/1ps
`default_nettype none
module scp_clock_ctrl
	import scp_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       clock_output_fuse,
	input  wire logic       divide_by_eight_fuse,
	input  wire logic       pin_io_out,
	input  wire logic       pin_io_oe,
	output logic            clock_output_pin_out,
	output logic            clock_output_pin_oe,
	output logic            sys_clk_en,
	output logic            pll_enable_out,
	output logic            pll_input_halver_out,
	output logic            pll_source_select_out,
	output logic            usb_postdivider_select_out,
	output logic            rc_osc_request
);
	typedef struct packed {
		logic [3:0]     div_code;
		logic           chg_en;
		logic [2:0]     chg_cnt;
		logic           halver;
		logic           pll_en;
		logic           src_sel;
		logic           usb_postdiv;
		logic [5:0]     pll_freq_low;
		logic           fuse_loaded;
		scp_div_state_e dstate;
		logic [7:0]     rdata;
		logic           pin_out;
		logic           pin_oe;
		logic           clk_en;
		logic           rc_req;
	} scp_ctrl_s;

	scp_ctrl_s state_reg;
	scp_ctrl_s state_next;

	logic div_tick;
	logic div_level;
	logic pll_locked;

	scp_divider u_div (
		.clk       (clk),
		.rst       (rst),
		.code      (state_reg.div_code),
		.tick      (div_tick),
		.clk_level (div_level)
	);

	scp_lock #(
		.LOCK_CYCLES (LOCK_CYCLES)
	) u_lock (
		.clk    (clk),
		.rst    (rst),
		.enable (state_reg.pll_en),
		.locked (pll_locked)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;

		// fuse-selected start divisor, caught after release
		if (!state_reg.fuse_loaded) begin
			state_next.fuse_loaded = 1'b1;
			state_next.div_code = divide_by_eight_fuse ? DIV_RESET_FUSED : DIV_RESET_PLAIN;
		end

		if (state_reg.chg_en) begin
			if (state_reg.chg_cnt <= 3'h1) begin
				state_next.chg_en  = 1'b0;
				state_next.chg_cnt = '0;
			end else begin
				state_next.chg_cnt = state_reg.chg_cnt - 3'h1;
			end
		end

		if (reg_wr && hit(reg_addr, SYSTEM_CLOCK_DIVIDER_ADDR)) begin
			// enable only with other bits zero
			if (reg_wdata == CHG_EN_ONLY) begin
				if (!state_reg.chg_en) begin
					state_next.chg_en  = 1'b1;
					state_next.chg_cnt = CHG_EN_WINDOW;
				end
			end else if (state_reg.chg_en && !reg_wdata[CHG_EN_BIT]) begin
				if (reg_wdata[3:0] <= DIV_CODE_MAX) begin
					state_next.div_code = reg_wdata[3:0];
				end
				state_next.chg_en  = 1'b0;
				state_next.chg_cnt = '0;
			end
		end

		if (reg_wr && hit(reg_addr, PLL_CONTROL_STATUS_ADDR)) begin
			// halver stored for the pll prescaler
			state_next.halver = reg_wdata[HALVER_BIT];
			state_next.pll_en = reg_wdata[PLL_ENABLE_BIT];
		end

		if (reg_wr && hit(reg_addr, PLL_FREQUENCY_CTRL_ADDR)) begin
			state_next.src_sel = reg_wdata[SRC_SEL_BIT];
			state_next.usb_postdiv = reg_wdata[USB_POSTDIV_BIT];
			// timer postscaler and pll ratio bits
			state_next.pll_freq_low = reg_wdata[5:0];
		end

		case (state_reg.dstate)
			SCP_RUN: begin
				if (state_next.div_code != state_reg.div_code) begin
					state_next.dstate = SCP_WAIT;
				end
			end
			SCP_WAIT: begin
				if (div_tick) begin
					state_next.dstate = SCP_EDGE;
				end
			end
			SCP_EDGE: begin
				if (div_tick) begin
					state_next.dstate = SCP_RUN;
				end
			end
			default: begin
				state_next.dstate = SCP_RUN;
			end
		endcase

		state_next.rdata = '0;
		if (reg_rd) begin
			if (hit(reg_addr, SYSTEM_CLOCK_DIVIDER_ADDR)) begin
				state_next.rdata = {state_reg.chg_en, 3'h0, state_reg.div_code};
			end else if (hit(reg_addr, PLL_CONTROL_STATUS_ADDR)) begin
				state_next.rdata = {state_reg.pll_en ? 8'h00 : 8'h00}
					| ({3'h0, state_reg.halver, 2'h0, state_reg.pll_en, 1'b0} & CTRL_MASK_PLLCS)
					| {7'h00, pll_locked};
			end else if (hit(reg_addr, PLL_FREQUENCY_CTRL_ADDR)) begin
				state_next.rdata = {state_reg.src_sel, state_reg.usb_postdiv,
					state_reg.pll_freq_low};
			end
		end

		// divided clock enable for synchronous domains
		state_next.clk_en = div_tick;

		if (clock_output_fuse) begin
			state_next.pin_out = div_level;
			state_next.pin_oe  = 1'b1;
		end else begin
			state_next.pin_out = pin_io_out;
			state_next.pin_oe  = pin_io_oe;
		end

		// rc oscillator on when pll runs from it
		state_next.rc_req = state_next.pll_en && state_next.src_sel;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg              <= '0;
			state_reg.pll_freq_low <= PLL_FREQ_RESET[5:0];
			state_reg.dstate       <= SCP_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all registered
	// ---------------------------------------------------------------
	assign reg_rdata                  = state_reg.rdata;
	assign clock_output_pin_out       = state_reg.pin_out;
	assign clock_output_pin_oe        = state_reg.pin_oe;
	assign sys_clk_en                 = state_reg.clk_en;
	assign pll_enable_out             = state_reg.pll_en;
	assign pll_input_halver_out       = state_reg.halver;
	assign pll_source_select_out      = state_reg.src_sel;
	assign usb_postdivider_select_out = state_reg.usb_postdiv;
	assign rc_osc_request             = state_reg.rc_req;
endmodule // scp_clock_ctrl
`default_nettype wire

// >>> hw/scp_pkg.sv
/*
 * scp_pkg: constants for the system clock prescaler and pll control block.
 * assumes: a byte-wide register port; registers at the offsets named here.
 */
package scp_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] PLL_CONTROL_STATUS_ADDR   = 8'h29;
	localparam logic [7:0] SYSTEM_CLOCK_DIVIDER_ADDR = 8'h61;
	localparam logic [7:0] PLL_FREQUENCY_CTRL_ADDR   = 8'h32;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CHG_EN_BIT      = 7;
	localparam int HALVER_BIT      = 4;
	localparam int PLL_ENABLE_BIT  = 1;
	localparam int LOCK_BIT        = 0;
	localparam int SRC_SEL_BIT     = 7;
	localparam int USB_POSTDIV_BIT = 6;

	// ---------------------------------------------------------------
	// reset values and codes
	// ---------------------------------------------------------------
	localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
	localparam logic [3:0] DIV_RESET_FUSED = 4'h3;
	localparam logic [3:0] DIV_CODE_MAX    = 4'h8;
	localparam logic [7:0] PLL_FREQ_RESET  = 8'h04;
	localparam logic [7:0] CTRL_MASK_PLLCS = 8'h12;
	localparam logic [7:0] CHG_EN_ONLY     = 8'h80;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam logic [2:0] CHG_EN_WINDOW   = 3'h4;
	localparam int         LOCK_CYCLES_DEF = 5000;
	localparam int         DIV_CNT_W       = 8;

	typedef enum logic [1:0] {
		SCP_RUN  = 2'b00,
		SCP_WAIT = 2'b01,
		SCP_EDGE = 2'b11
	} scp_div_state_e;

	// divisor code to terminal count (divisor minus one)
	function automatic logic [DIV_CNT_W-1:0] scp_div_term(input logic [3:0] code);
		scp_div_term = DIV_CNT_W'((9'h001 << code) - 9'h001);
	endfunction
endpackage

// >>> hw/scp_divider.sv
/*
 * scp_divider: glitch-free power-of-two divider producing a clock enable
 * and a divided clock level.
 * assumes: code is already legal; the master clock runs free.
 */
`timescale 1ns/1ps
`default_nettype none
module scp_divider
	import scp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] code,
	output logic            tick,
	output logic            clk_level
);
	typedef struct packed {
		logic [DIV_CNT_W-1:0] cnt;
		logic [DIV_CNT_W-1:0] term;
		logic                 tick;
		logic                 level;
	} scp_div_s;

	scp_div_s state_reg;
	scp_div_s state_next;

	// ---------------------------------------------------------------
	// counter; new terminal taken only at a period boundary
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.cnt >= state_reg.term) begin
			state_next.cnt  = '0;
			state_next.tick = 1'b1;
			state_next.term = scp_div_term(code);
		end else begin
			state_next.cnt = state_reg.cnt + DIV_CNT_W'(1);
		end
		state_next.level = (state_next.term == '0) ? ~state_reg.level
			: (state_next.cnt <= (state_next.term >> 1));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick      = state_reg.tick;
	assign clk_level = state_reg.level;
endmodule // scp_divider
`default_nettype wire

// >>> hw/scp_lock.sv
/*
 * scp_lock: lock model for the pll; counts reference cycles after enable.
 * assumes: enable is a register level in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module scp_lock
	import scp_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic enable,
	output logic      locked
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        locked;
	} scp_lock_s;

	scp_lock_s state_reg;
	scp_lock_s state_next;

	// ---------------------------------------------------------------
	// lock counter
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		if (!enable) begin
			state_next = '0;
		end else if (state_reg.cnt >= 16'(LOCK_CYCLES - 1)) begin
			state_next.locked = 1'b1;
		end else begin
			state_next.cnt = state_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign locked = state_reg.locked;
endmodule // scp_lock
`default_nettype wire

// >>> bench/scp_checker.sv
/* scp_checker: port assertions for scp_clock_ctrl.
   assumes: bound to the top module; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module scp_checker
	import scp_pkg::*;
#(
	parameter int LOCK_CYCLES = 8
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       clock_output_fuse,
	input wire logic       pin_io_out,
	input wire logic       pin_io_oe,
	input wire logic       clock_output_pin_out,
	input wire logic       clock_output_pin_oe,
	input wire logic       sys_clk_en,
	input wire logic       pll_enable_out,
	input wire logic       pll_input_halver_out,
	input wire logic       pll_source_select_out,
	input wire logic       usb_postdivider_select_out,
	input wire logic       rc_osc_request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic rd_ctl = reg_rd && (reg_addr == PLL_CONTROL_STATUS_ADDR);
	wire logic wr_ctl = reg_wr && (reg_addr == PLL_CONTROL_STATUS_ADDR);
	wire logic wr_frq = reg_wr && (reg_addr == PLL_FREQUENCY_CTRL_ADDR);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_pin_oe; clock_output_fuse |=> clock_output_pin_oe; endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("pin not taken over");
	property p_pin_io; !clock_output_fuse |=> clock_output_pin_out == $past(pin_io_out)
		&& clock_output_pin_oe == $past(pin_io_oe); endproperty
	a_pin_io: assert property (p_pin_io) else $error("pin io path wrong");
	property p_resv; rd_ctl |=> reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	property p_rdback; rd_ctl |=> reg_rdata[1] == $past(pll_enable_out)
		&& reg_rdata[4] == $past(pll_input_halver_out); endproperty
	a_rdback: assert property (p_rdback) else $error("control readback wrong");
	property p_unlock; rd_ctl && !pll_enable_out && !$past(pll_enable_out) |=> !reg_rdata[0];
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock without enable");
	property p_wctl; wr_ctl |=> pll_enable_out == $past(reg_wdata[1])
		&& pll_input_halver_out == $past(reg_wdata[4]); endproperty
	a_wctl: assert property (p_wctl) else $error("control write lost");
	property p_wfrq; wr_frq |=> pll_source_select_out == $past(reg_wdata[7])
		&& usb_postdivider_select_out == $past(reg_wdata[6]); endproperty
	a_wfrq: assert property (p_wfrq) else $error("frequency write lost");
	property p_hold; !wr_ctl |=> $stable(pll_enable_out); endproperty
	a_hold: assert property (p_hold) else $error("enable moved unwritten");
	property p_rc_on; (pll_enable_out && pll_source_select_out) [*2] |-> rc_osc_request;
	endproperty
	a_rc_on: assert property (p_rc_on) else $error("oscillator not requested");
	property p_rc_off; (!pll_enable_out) [*2] |-> !rc_osc_request; endproperty
	a_rc_off: assert property (p_rc_off) else $error("oscillator kept on");
	c_lock: cover property (rd_ctl ##1 reg_rdata[0]);
	c_fuse: cover property (clock_output_fuse && sys_clk_en);
	c_rc: cover property (rc_osc_request);
endmodule // scp_checker
bind scp_clock_ctrl scp_checker #(.LOCK_CYCLES(LOCK_CYCLES)) scp_checker_inst (.clk(clk),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .clock_output_fuse(clock_output_fuse), .pin_io_out(pin_io_out),
	.pin_io_oe(pin_io_oe), .clock_output_pin_out(clock_output_pin_out),
	.clock_output_pin_oe(clock_output_pin_oe), .sys_clk_en(sys_clk_en),
	.pll_enable_out(pll_enable_out), .pll_input_halver_out(pll_input_halver_out),
	.pll_source_select_out(pll_source_select_out),
	.usb_postdivider_select_out(usb_postdivider_select_out), .rc_osc_request(rc_osc_request));
`default_nettype wire

// >>> bench/tb.sv
/* tb: register-level tests of scp_clock_ctrl.
   assumes: lock count shortened to 8; clock 250 MHz. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb
	import scp_pkg::*;
;
	localparam logic [7:0] DV = SYSTEM_CLOCK_DIVIDER_ADDR;
	localparam logic [7:0] CT = PLL_CONTROL_STATUS_ADDR;
	localparam logic [7:0] FQ = PLL_FREQUENCY_CTRL_ADDR;
	logic       clk;
	logic       rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pin_io_out = 1'b0, pin_io_oe = 1'b0;
	logic       fo = 1'b0, f8 = 1'b0, last;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	wire logic [7:0] rdat;
	wire logic  pin_o, pin_oe, tick, pe, ph, ps, pu, rc;
	int         n_fail = 0, checks_done = 0, n;
	scp_clock_ctrl #(.LOCK_CYCLES(8)) scp_clock_ctrl_inst (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(rdat), .clock_output_fuse(fo), .divide_by_eight_fuse(f8),
		.pin_io_out(pin_io_out), .pin_io_oe(pin_io_oe), .clock_output_pin_out(pin_o),
		.clock_output_pin_oe(pin_oe), .sys_clk_en(tick), .pll_enable_out(pe),
		.pll_input_halver_out(ph), .pll_source_select_out(ps),
		.usb_postdivider_select_out(pu), .rc_osc_request(rc));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(nm, e, rdat)
	endtask
	task automatic setdiv(input logic [3:0] c);
		// two writes two cycles apart, inside the change enable window
		wr(DV, CHG_EN_ONLY);
		wr(DV, {4'h0, c});
		repeat (600) @(posedge clk);
	endtask
	task automatic meas(input int e, input string nm);
		int p;
		p = 0;
		while (tick !== 1'b1 && p < 600) begin
			@(posedge clk);
			#1;
			p++;
		end
		p = 0;
		do begin
			@(posedge clk);
			#1;
			p++;
		end while (tick !== 1'b1 && p < 600);
		`CHK(nm, e, p)
	endtask
	task automatic do_rst(input logic o, input logic d);
		@(posedge clk);
		rst <= 1'b1;
		fo <= o;
		f8 <= d;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		do_rst(1'b0, 1'b0);
		rd(DV, 8'h00, "div_rst");
		rd(CT, 8'h00, "ctl_rst");
		rd(8'h77, 8'h00, "unmapped");
		rd(FQ, PLL_FREQ_RESET, "frq_rst");
		meas(1, "per_0");
		pin_io_out <= 1'b1;
		pin_io_oe <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("pin_io", 2'b11, {pin_o, pin_oe})
		for (int c = 1; c <= 8; c++) begin
			setdiv(4'(c));
			rd(DV, 8'(c), "div_rd");
			meas(1 << c, "per");
		end
		setdiv(4'h1);
		wr(DV, 8'h02);
		rd(DV, 8'h01, "no_pce");
		wr(DV, 8'h81);
		wr(DV, 8'h02);
		rd(DV, 8'h01, "pce_mixed");
		wr(DV, CHG_EN_ONLY);
		wr(DV, 8'h09);
		rd(DV, 8'h01, "reserved");
		wr(DV, CHG_EN_ONLY);
		rd(DV, 8'h81, "pce_set");
		wr(DV, CHG_EN_ONLY);
		wr(DV, 8'h02);
		rd(DV, 8'h01, "no_restart");
		wr(DV, CHG_EN_ONLY);
		repeat (2) @(posedge clk);
		wr(DV, 8'h02);
		rd(DV, 8'h02, "pce_edge");
		repeat (600) @(posedge clk);
		meas(4, "per_2");
		wr(CT, 8'h12);
		rd(CT, 8'h12, "ctl_en");
		`CHK("pll_out", 2'b11, {pe, ph})
		repeat (12) @(posedge clk);
		rd(CT, 8'h13, "lock");
		wr(CT, 8'hFF);
		rd(CT, 8'h13, "resv");
		wr(CT, 8'h10);
		rd(CT, 8'h10, "unlock");
		wr(FQ, 8'hC0);
		rd(FQ, 8'hC0, "frq");
		`CHK("frq_out", 2'b11, {ps, pu})
		wr(CT, 8'h02);
		repeat (3) @(posedge clk);
		`CHK("rc_on", 1'b1, rc)
		wr(FQ, 8'h00);
		repeat (3) @(posedge clk);
		`CHK("rc_off", 2'b00, {rc, ps})
		pin_io_oe <= 1'b0;
		do_rst(1'b1, 1'b1);
		rd(DV, 8'h03, "div_fused");
		meas(8, "per_8");
		`CHK("pin_oe", 1'b1, pin_oe)
		n = 0;
		last = pin_o;
		repeat (80) begin
			@(posedge clk);
			#1;
			if (pin_o && !last) n++;
			last = pin_o;
		end
		`CHK("pin_rises", 10, n)
		setdiv(4'h0);
		meas(1, "per_f0");
		end_sim;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		end_sim;
	end
endmodule // tb
`default_nettype wire
